//--- rtl/tsr_config_regs.sv
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_config_regs #(
	parameter int         DATA_W    = 8,
	parameter logic [7:0] FAMILY_ID = 8'ha5, // Arbitrary value
	parameter logic [7:0] MASK_ID   = 8'h01  // Arbitrary value
) (
	input  wire logic       sys_clk_in,
	input  wire logic       nrst_in,
	input  wire logic [7:0] reg_loc_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	output logic            reg_rvalid_out,
	input  wire logic       seq_download_done_in,
	output logic            defaults_valid_out,
	input  wire logic       exposure_trigger_in,
	input  wire logic [2:0] frame_sel_in,
	input  wire logic       integrating_in,
	input  wire logic       modulation_in,
	output logic            illum_drive_out,
	output logic      [1:0] first_gate_pair_zero_out,
	output logic      [1:0] first_gate_pair_one_out,
	output logic      [1:0] second_gate_pair_zero_out,
	output logic      [1:0] second_gate_pair_one_out,
	output logic      [2:0] first_illum_mode_out,
	output logic      [2:0] second_illum_mode_out,
	output logic      [2:0] gray_illum_mode_out,
	output logic      [7:0] ee_addr_out,
	output logic      [7:0] ee_wdata_out,
	output logic            ee_write_out,
	output logic            ee_read_out,
	input  wire logic [7:0] ee_rdata_in,
	input  wire logic       ee_rvalid_in
);

	// Storage, read mux and merge masks are all byte wide; refuse anything else.
	if (DATA_W != 8) begin : g_width_check
		$error("tsr_config_regs supports only 8-bit registers");
	end

	// Shadow copies hold the host view, working copies the frame view
	logic [7:0] ph1_sh_q;
	logic [7:0] ph2_sh_q;
	logic [7:0] il1_sh_q;
	logic [7:0] il2_sh_q;
	logic [7:0] ilg_sh_q;
	logic [7:0] ph1_q;
	logic [7:0] ph2_q;
	logic [7:0] il1_q;
	logic [7:0] il2_q;
	logic [7:0] ilg_q;
	logic [7:0] ee_addr_q;
	logic [7:0] ee_data_q;
	logic       defaults_q;
	logic [7:0] rdata_d;
	logic       wr_ph1;
	logic       wr_ph2;
	logic       wr_il1;
	logic       wr_il2;
	logic       wr_ilg;
	logic       wr_ea;
	logic       wr_ed;

	// Reserved locations are not stored, so nothing written there can persist.
	assign wr_ph1 = reg_wr_in && reg_loc_in == `TSR_LOC_PHASE_FIRST;
	assign wr_ph2 = reg_wr_in && reg_loc_in == `TSR_LOC_PHASE_SECOND;
	assign wr_il1 = reg_wr_in && reg_loc_in == `TSR_LOC_ILLUM_FIRST;
	assign wr_il2 = reg_wr_in && reg_loc_in == `TSR_LOC_ILLUM_SECOND;
	assign wr_ilg = reg_wr_in && reg_loc_in == `TSR_LOC_ILLUM_GRAY;
	// EEPROM port strobes
	assign wr_ea  = reg_wr_in && reg_loc_in == `TSR_LOC_EE_ADDR;
	assign wr_ed  = reg_wr_in && reg_loc_in == `TSR_LOC_EE_DATA;

	function automatic logic [7:0] ph_merge(
		input logic [7:0] old_v,
		input logic [7:0] new_v
	);
		ph_merge = (old_v & `TSR_PH_RSVD_MASK) | (new_v & ~`TSR_PH_RSVD_MASK);
	endfunction : ph_merge

	function automatic logic [7:0] il_merge(
		input logic [7:0] old_v,
		input logic [7:0] new_v
	);
		il_merge = (old_v & ~`TSR_IL_WRITE_MASK) | (new_v & `TSR_IL_WRITE_MASK);
	endfunction : il_merge

	// Shadow copies: host side, take writes at any time
	// Download reloads factory values over any host write in the same cycle.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ph1_sh_q <= `TSR_RST_PHASE_FIRST;
		else if (seq_download_done_in)
			ph1_sh_q <= `TSR_RST_PHASE_FIRST;
		else if (wr_ph1)
			ph1_sh_q <= ph_merge(ph1_sh_q, reg_wdata_in);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ph2_sh_q <= `TSR_RST_PHASE_SECOND;
		else if (seq_download_done_in)
			ph2_sh_q <= `TSR_RST_PHASE_SECOND;
		else if (wr_ph2)
			ph2_sh_q <= ph_merge(ph2_sh_q, reg_wdata_in);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			il1_sh_q <= `TSR_RST_ILLUM_FIRST;
		else if (seq_download_done_in)
			il1_sh_q <= `TSR_RST_ILLUM_FIRST;
		else if (wr_il1)
			il1_sh_q <= il_merge(il1_sh_q, reg_wdata_in);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			il2_sh_q <= `TSR_RST_ILLUM_SECOND;
		else if (seq_download_done_in)
			il2_sh_q <= `TSR_RST_ILLUM_SECOND;
		else if (wr_il2)
			il2_sh_q <= il_merge(il2_sh_q, reg_wdata_in);
	end

	// Grayscale starts dark: the off bit is part of its factory value.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ilg_sh_q <= `TSR_RST_ILLUM_GRAY;
		else if (seq_download_done_in)
			ilg_sh_q <= `TSR_RST_ILLUM_GRAY;
		else if (wr_ilg)
			ilg_sh_q <= il_merge(ilg_sh_q, reg_wdata_in);
	end

	// Working copies: change only at the trigger or a download, so a frame never sees a torn setting.
	// A write in the trigger cycle lands in the shadow and waits for the next trigger.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ph1_q <= `TSR_RST_PHASE_FIRST;
		else if (seq_download_done_in)
			ph1_q <= `TSR_RST_PHASE_FIRST;
		else if (exposure_trigger_in)
			ph1_q <= ph1_sh_q;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ph2_q <= `TSR_RST_PHASE_SECOND;
		else if (seq_download_done_in)
			ph2_q <= `TSR_RST_PHASE_SECOND;
		else if (exposure_trigger_in)
			ph2_q <= ph2_sh_q;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			il1_q <= `TSR_RST_ILLUM_FIRST;
		else if (seq_download_done_in)
			il1_q <= `TSR_RST_ILLUM_FIRST;
		else if (exposure_trigger_in)
			il1_q <= il1_sh_q;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			il2_q <= `TSR_RST_ILLUM_SECOND;
		else if (seq_download_done_in)
			il2_q <= `TSR_RST_ILLUM_SECOND;
		else if (exposure_trigger_in)
			il2_q <= il2_sh_q;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ilg_q <= `TSR_RST_ILLUM_GRAY;
		else if (seq_download_done_in)
			ilg_q <= `TSR_RST_ILLUM_GRAY;
		else if (exposure_trigger_in)
			ilg_q <= ilg_sh_q;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			defaults_q <= 1'b0;
		else if (seq_download_done_in)
			defaults_q <= 1'b1;
	end

	// Indirect EEPROM port
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ee_addr_q <= `TSR_RST_EE_ADDR;
		end else if (reg_wr_in && reg_loc_in == `TSR_LOC_EE_ADDR) begin
			ee_addr_q <= reg_wdata_in;
		end
	end

	// A host write beats a returning EEPROM byte in the same cycle.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ee_data_q <= `TSR_RST_EE_DATA;
		else if (wr_ed)
			ee_data_q <= reg_wdata_in;
		else if (ee_rvalid_in)
			ee_data_q <= ee_rdata_in;
	end

	// One-cycle strobe per host byte; the EEPROM side must take it then.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ee_write_out <= 1'b0;
		else
			ee_write_out <= wr_ed;
	end

	// The address write doubles as the fetch request; there is no read command.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ee_read_out <= 1'b0;
		else
			ee_read_out <= wr_ea;
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			ee_wdata_out <= 8'h00;
		else if (wr_ed)
			ee_wdata_out <= reg_wdata_in;
	end

	assign ee_addr_out = ee_addr_q;

	// Read mux shows the shadow, i.e. what the next frame will use
	always_comb begin
		case (reg_loc_in)
			`TSR_LOC_FAMILY_ID:    rdata_d = FAMILY_ID;
			`TSR_LOC_MASK_VERSION: rdata_d = MASK_ID;
			`TSR_LOC_EE_ADDR:      rdata_d = ee_addr_q;
			`TSR_LOC_EE_DATA:      rdata_d = ee_data_q;
			`TSR_LOC_PHASE_FIRST:  rdata_d = ph1_sh_q;
			`TSR_LOC_ILLUM_FIRST:  rdata_d = il1_sh_q;
			`TSR_LOC_PHASE_SECOND: rdata_d = ph2_sh_q;
			`TSR_LOC_ILLUM_SECOND: rdata_d = il2_sh_q;
			`TSR_LOC_ILLUM_GRAY:   rdata_d = ilg_sh_q;
			default:               rdata_d = `TSR_RESERVED_READ;
		endcase
	end

	// Answer is a single pulse one cycle after the read strobe.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			reg_rvalid_out <= 1'b0;
		else
			reg_rvalid_out <= reg_rd_in;
	end

	// Read data holds until the next read so a slow host can still take it.
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_d;
	end

	// Off wins over on so an undefined pairing never lights the emitter.
	function automatic tsr_pkg::tsr_illum_mode_type il_mode(input logic [7:0] v);
		if (v[`TSR_IL_OFF_BIT])
			il_mode = tsr_pkg::TSR_ILLUM_OFF;
		else if (v[`TSR_IL_ON_BIT])
			il_mode = tsr_pkg::TSR_ILLUM_ON;
		else
			il_mode = tsr_pkg::TSR_ILLUM_MODULATED;
	endfunction : il_mode

	tsr_pkg::tsr_illum_mode_type mode_first;
	tsr_pkg::tsr_illum_mode_type mode_second;
	tsr_pkg::tsr_illum_mode_type mode_gray;
	tsr_pkg::tsr_illum_mode_type mode_cur;

	assign mode_first  = il_mode(il1_q);
	assign mode_second = il_mode(il2_q);
	assign mode_gray   = il_mode(ilg_q);

	always_comb begin
		case (frame_sel_in)
			tsr_pkg::TSR_FRAME_FIRST:  mode_cur = mode_first;
			tsr_pkg::TSR_FRAME_SECOND: mode_cur = mode_second;
			tsr_pkg::TSR_FRAME_GRAY:   mode_cur = mode_gray;
			default:                   mode_cur = tsr_pkg::TSR_ILLUM_OFF;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			illum_drive_out <= 1'b0;
		end else if (!integrating_in) begin
			illum_drive_out <= 1'b0;
		end else begin
			case (mode_cur)
				tsr_pkg::TSR_ILLUM_MODULATED: illum_drive_out <= modulation_in;
				tsr_pkg::TSR_ILLUM_ON:        illum_drive_out <= 1'b1;
				tsr_pkg::TSR_ILLUM_OFF:       illum_drive_out <= 1'b0;
				default:                      illum_drive_out <= 1'b0;
			endcase
		end
	end

	assign first_gate_pair_zero_out  = ph1_q[`TSR_PH_PAIR0_LSB +: 2];
	assign first_gate_pair_one_out   = ph1_q[`TSR_PH_PAIR1_LSB +: 2];
	assign second_gate_pair_zero_out = ph2_q[`TSR_PH_PAIR0_LSB +: 2];
	assign second_gate_pair_one_out  = ph2_q[`TSR_PH_PAIR1_LSB +: 2];
	assign first_illum_mode_out      = mode_first;
	assign second_illum_mode_out     = mode_second;
	assign gray_illum_mode_out       = mode_gray;
	assign defaults_valid_out        = defaults_q;

endmodule : tsr_config_regs

//--- rtl/tsr_cfg.svh
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

// Register locations on the paged register port
`define TSR_LOC_FAMILY_ID      8'h00
`define TSR_LOC_MASK_VERSION   8'h01
`define TSR_LOC_EE_ADDR        8'h11
`define TSR_LOC_EE_DATA        8'h12
`define TSR_LOC_PHASE_FIRST    8'h22
`define TSR_LOC_ILLUM_FIRST    8'h24
`define TSR_LOC_PHASE_SECOND   8'h25
`define TSR_LOC_ILLUM_SECOND   8'h27
`define TSR_LOC_ILLUM_GRAY     8'h3c

// Factory values
`define TSR_RST_PHASE_FIRST    8'h34
`define TSR_RST_PHASE_SECOND   8'h3d
`define TSR_RST_ILLUM_FIRST    8'h00
`define TSR_RST_ILLUM_SECOND   8'h00
`define TSR_RST_ILLUM_GRAY     8'h26
`define TSR_RST_EE_ADDR        8'h00
`define TSR_RST_EE_DATA        8'h00
`define TSR_RESERVED_READ      8'h00

// Phase select fields
`define TSR_PH_PAIR0_LSB       0
`define TSR_PH_PAIR1_LSB       2
`define TSR_PH_RSVD_MASK       8'hf0

// Illumination control fields
`define TSR_IL_ON_BIT          4
`define TSR_IL_OFF_BIT         5
`define TSR_IL_WRITE_MASK      8'h30

`endif

//--- rtl/tsr_pkg.sv
package tsr_pkg;

	typedef enum logic [2:0] {
		TSR_ILLUM_MODULATED = 3'b001,
		TSR_ILLUM_ON        = 3'b010,
		TSR_ILLUM_OFF       = 3'b100
	} tsr_illum_mode_type;

	typedef enum logic [2:0] {
		TSR_FRAME_FIRST  = 3'b001,
		TSR_FRAME_SECOND = 3'b010,
		TSR_FRAME_GRAY   = 3'b100
	} tsr_frame_type;

endpackage : tsr_pkg

//--- testbench/tsr_config_regs_props.sv
`timescale 1ns/1ps
module tsr_config_regs_props #(
	parameter logic [7:0] FAMILY_ID = 8'ha5,
	parameter logic [7:0] MASK_ID   = 8'h01
) (
	input wire logic       sys_clk_in,
	input wire logic       nrst_in,
	input wire logic [7:0] reg_loc_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       seq_download_done_in,
	input wire logic       defaults_valid_out,
	input wire logic       exposure_trigger_in,
	input wire logic [2:0] frame_sel_in,
	input wire logic       integrating_in,
	input wire logic       modulation_in,
	input wire logic       illum_drive_out,
	input wire logic [1:0] first_gate_pair_zero_out,
	input wire logic [1:0] first_gate_pair_one_out,
	input wire logic [2:0] gray_illum_mode_out,
	input wire logic [7:0] ee_addr_out,
	input wire logic [7:0] ee_wdata_out,
	input wire logic       ee_write_out,
	input wire logic       ee_read_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	a_family_id_read: assert property (reg_rd_in && reg_loc_in == 8'h00
		|=> reg_rdata_out == FAMILY_ID) else $error("family code wrong");
	a_mask_id_read: assert property (reg_rd_in && reg_loc_in == 8'h01
		|=> reg_rdata_out == MASK_ID) else $error("mask code wrong");
	a_ee_addr_req: assert property (reg_wr_in && reg_loc_in == 8'h11
		|=> ee_read_out && ee_addr_out == $past(reg_wdata_in)) else $error("ee read bad");
	a_ee_data_wr: assert property (reg_wr_in && reg_loc_in == 8'h12
		|=> ee_write_out && ee_wdata_out == $past(reg_wdata_in)) else $error("ee write bad");
	a_phase_held: assert property (!exposure_trigger_in && !seq_download_done_in
		|=> $stable({first_gate_pair_zero_out, first_gate_pair_one_out}))
		else $error("phase moved early");
	a_dl_defaults: assert property (seq_download_done_in |=> defaults_valid_out
		&& first_gate_pair_zero_out == 2'h0 && first_gate_pair_one_out == 2'h1)
		else $error("defaults not loaded");
	a_gray_dark: assert property (integrating_in && frame_sel_in == 3'h4
		&& gray_illum_mode_out == 3'h4 |=> !illum_drive_out) else $error("light on");
	a_idle_dark: assert property (!integrating_in |=> !illum_drive_out)
		else $error("light outside integration");
endmodule : tsr_config_regs_props
bind tsr_config_regs tsr_config_regs_props #(.FAMILY_ID(FAMILY_ID), .MASK_ID(MASK_ID)) chk (.*);

//--- testbench/tsr_ee_model.sv
`timescale 1ns/1ps
module tsr_ee_model (
	input wire logic       clk_in,
	input wire logic       read_in,
	input wire logic [7:0] addr_in,
	output logic     [7:0] data_out = 8'h00,
	output logic           valid_out = 1'h0
);
	logic [1:0] dly_q = 2'h0;
	logic [7:0] addr_q = 8'h00;
	// Idle data toggles so a stale byte is never mistaken for an answer
	always @(posedge clk_in) begin
		dly_q <= {dly_q[0], read_in};
		if (read_in) addr_q <= addr_in;
		valid_out <= dly_q[1];
		data_out <= dly_q[1] ? addr_q ^ 8'h5a : ~data_out;
	end
endmodule : tsr_ee_model

//--- testbench/tof_sensor_config_registers_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("[FAIL] %0t mismatch", $time); end end
module tof_sensor_config_registers_bench;
	logic sys_clk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0, seq_download_done_in = 0;
	logic exposure_trigger_in = 0, integrating_in = 0, modulation_in = 0, ee_rvalid_in;
	logic reg_rvalid_out, defaults_valid_out, illum_drive_out, ee_write_out, ee_read_out;
	logic [7:0] reg_loc_in = 0, reg_wdata_in = 0, reg_rdata_out, ee_addr_out, ee_wdata_out, ee_rdata_in;
	logic [2:0] frame_sel_in = 0, first_illum_mode_out, second_illum_mode_out, gray_illum_mode_out;
	logic [1:0] first_gate_pair_zero_out, first_gate_pair_one_out;
	logic [1:0] second_gate_pair_zero_out, second_gate_pair_one_out;
	int         bad_count = 0, tests_run = 0, cyc = 0;
	tsr_config_regs #(.FAMILY_ID(8'h5b), .MASK_ID(8'h07)) uut (.*);
	tsr_ee_model ee (.clk_in(sys_clk_in), .read_in(ee_read_out), .addr_in(ee_addr_out),
		.data_out(ee_rdata_in), .valid_out(ee_rvalid_in));
	initial forever #5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (++cyc == 3000) begin
		bad_count++;
		stop_test();
	end
	task automatic stop_test();
		$display("errors %0d checks %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] l, d);
		@(negedge sys_clk_in) {reg_loc_in, reg_wdata_in, reg_wr_in} = {l, d, 1'h1};
		@(negedge sys_clk_in) reg_wr_in = 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] l, e);
		@(negedge sys_clk_in) {reg_loc_in, reg_rd_in} = {l, 1'h1};
		@(negedge sys_clk_in) reg_rd_in = 1'h0;
		`CHK(reg_rvalid_out, 1'h1)
		`CHK(reg_rdata_out, e)
	endtask : rd
	task automatic trig();
		@(negedge sys_clk_in) exposure_trigger_in = 1'h1;
		@(negedge sys_clk_in) exposure_trigger_in = 1'h0;
	endtask : trig
	task automatic ck_ill(input logic m, e);
		@(negedge sys_clk_in) modulation_in = m;
		@(negedge sys_clk_in) `CHK(illum_drive_out, e)
	endtask : ck_ill
	task automatic t_defaults();
		rd(8'h00, 8'h5b);
		rd(8'h01, 8'h07);
		wr(8'h00, 8'h5c);
		rd(8'h00, 8'h5b);
		rd(8'h25, 8'h3d);
		rd(8'h24, 8'h00);
		rd(8'h27, 8'h00);
		rd(8'h30, 8'h00);
		`CHK(defaults_valid_out, 1'h0)
		@(negedge sys_clk_in) seq_download_done_in = 1'h1;
		@(negedge sys_clk_in) seq_download_done_in = 1'h0;
		`CHK(defaults_valid_out, 1'h1)
	endtask : t_defaults
	task automatic t_phase();
		for (int i = 0; i < 4; i++) begin
			wr(8'h22, 8'(i * 5));
			rd(8'h22, 8'h30 | 8'(i * 5));
			`CHK(first_gate_pair_zero_out, 2'(i == 0 ? 0 : i - 1))
			trig();
			`CHK(first_gate_pair_zero_out, 2'(i))
			`CHK(first_gate_pair_one_out, 2'(i))
		end
		wr(8'h25, 8'h09);
		trig();
		`CHK({second_gate_pair_one_out, second_gate_pair_zero_out}, 4'h9)
	endtask : t_phase
	task automatic t_illum();
		{integrating_in, frame_sel_in} = {1'h1, 3'h1};
		wr(8'h24, 8'h10);
		trig();
		ck_ill(1'h0, 1'h1);
		wr(8'h24, 8'h20);
		trig();
		ck_ill(1'h1, 1'h0);
		wr(8'h24, 8'hdf);
		rd(8'h24, 8'h10);
		wr(8'h24, 8'h00);
		trig();
		ck_ill(1'h1, 1'h1);
		ck_ill(1'h0, 1'h0);
		frame_sel_in = 3'h4;
		ck_ill(1'h1, 1'h0);
		integrating_in = 1'h0;
	endtask : t_illum
	task automatic t_eeprom();
		wr(8'h11, 8'h40);
		repeat (6) @(negedge sys_clk_in);
		rd(8'h12, 8'h1a);
		rd(8'h11, 8'h40);
		wr(8'h12, 8'h77);
		`CHK(ee_wdata_out, 8'h77)
		`CHK(ee_write_out, 1'h1)
		rd(8'h12, 8'h77);
	endtask : t_eeprom
	task automatic t_reset();
		@(negedge sys_clk_in) nrst_in = 1'h0;
		@(negedge sys_clk_in) nrst_in = 1'h1;
		`CHK(defaults_valid_out, 1'h0)
		rd(8'h22, 8'h34);
		rd(8'h3c, 8'h26);
	endtask : t_reset
	initial begin
		repeat (20) @(negedge sys_clk_in);
		nrst_in = 1'h1;
		t_defaults();
		t_phase();
		t_illum();
		t_eeprom();
		t_reset();
		stop_test();
	end
endmodule : tof_sensor_config_registers_bench
